// File: verilog/tape_write_start.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module tape_write_start
    import tape_wr_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_DELAY_CYC,
    parameter int LONG_CYC = LONG_DELAY_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_end_pulse_a,
    input wire logic write_end_pulse_b,
    input wire logic forward_read,
    input wire logic write_preset_pulse,
    input wire logic slot_strobe,
    input wire logic clear_window_phase,
    input wire logic tape_write_cycle,
    input wire logic lower_preset_in,
    input wire logic word_loaded_ack,
    input wire logic motion_start,
    input wire logic first_block,
    input wire logic bad_spot_pending,
    input wire logic inhibit_set,
    input wire logic inhibit_release,
    output logic forward_motion_ind,
    output logic write_in_use,
    output logic write_available_a,
    output logic write_available_b,
    output logic write_available_c,
    output logic buffer_clear,
    output logic preset_out,
    output logic clear_done_request,
    output logic second_word_request,
    output logic start_confirm_pulse,
    output logic write_operate,
    output logic [7:0] density_ppi,
    output logic [7:0] gap_tenths
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [2:0] wea_s, web_s, wpr_s, ack_s, mot_s;
    logic wea_p, web_p, wpr_p, ack_p, mot_p;

    function automatic logic rise3(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wea_s <= '0;
            web_s <= '0;
            wpr_s <= '0;
            ack_s <= '0;
            mot_s <= '0;
        end else begin
            wea_s <= {wea_s[1:0], write_end_pulse_a};
            web_s <= {web_s[1:0], write_end_pulse_b};
            wpr_s <= {wpr_s[1:0], write_preset_pulse};
            ack_s <= {ack_s[1:0], word_loaded_ack};
            mot_s <= {mot_s[1:0], motion_start};
        end
    end

    assign wea_p = rise3(wea_s);
    assign web_p = rise3(web_s);
    assign wpr_p = rise3(wpr_s);
    assign ack_p = rise3(ack_s);
    assign mot_p = rise3(mot_s);

    // ****************************************
    // APB slave
    // ****************************************
    logic low_q, high_q, short_q, variant_q;
    logic preset_q, clear_q, firstreq_q, bufrdy_q, taperdy_q, start_q, wrdy_q, inhibit_q;
    logic wr_en, rd_en, setup_wr, start_wr, mapped;
    logic [3:0] op_digit;
    logic gap_digit;

    assign mapped = (paddr == MODE_OFS) || (paddr == CTRL_OFS) || (paddr == STAT_OFS) || (paddr == SETUP_OFS);
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && !penable && !pwrite;
    assign setup_wr = wr_en && (paddr == SETUP_OFS);
    assign start_wr = wr_en && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT];
    assign op_digit = pwdata[SETUP_OP_LSB +: 4];
    assign gap_digit = pwdata[SETUP_GAP_BIT];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RESET_WORD;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rd_en) begin
                prdata <= RESET_WORD;
                case (paddr)
                    MODE_OFS: begin
                        prdata[MODE_LOW_BIT] <= low_q;
                        prdata[MODE_HIGH_BIT] <= high_q;
                        prdata[MODE_SHORT_BIT] <= short_q;
                        prdata[MODE_VARIANT_BIT] <= variant_q;
                    end
                    STAT_OFS: begin
                        prdata[STAT_PRESET_BIT] <= preset_q;
                        prdata[STAT_CLEAR_BIT] <= clear_q;
                        prdata[STAT_FIRSTREQ_BIT] <= firstreq_q;
                        prdata[STAT_BUFRDY_BIT] <= bufrdy_q;
                        prdata[STAT_TAPERDY_BIT] <= taperdy_q;
                        prdata[STAT_START_BIT] <= start_q;
                        prdata[STAT_WRDY_BIT] <= wrdy_q;
                        prdata[STAT_INHIBIT_BIT] <= inhibit_q;
                    end
                    default: begin
                        prdata <= RESET_WORD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            variant_q <= 1'b0;
        end else if (wr_en && paddr == MODE_OFS) begin
            variant_q <= pwdata[MODE_VARIANT_BIT];
        end
    end

    // ****************************************
    // Mode flags
    // ****************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_q <= 1'b0;
            high_q <= 1'b0;
        end else if (setup_wr && op_digit == OP_LOW_DENSITY) begin
            low_q <= 1'b1;
            high_q <= 1'b0;
        end else if (setup_wr && op_digit == OP_HIGH_DENSITY) begin
            high_q <= 1'b1;
            low_q <= 1'b0;
        end else if (web_p) begin
            low_q <= 1'b0;
            high_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            short_q <= 1'b0;
        end else if (setup_wr && (op_digit == OP_LOW_DENSITY || op_digit == OP_HIGH_DENSITY)
                     && gap_digit == GAP_SHORT) begin
            short_q <= 1'b1;
        end else if (wea_p) begin
            short_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            forward_motion_ind <= 1'b0;
            write_in_use <= 1'b0;
            write_available_a <= 1'b0;
            write_available_b <= 1'b0;
            write_available_c <= 1'b0;
            density_ppi <= 8'h00;
            gap_tenths <= 8'h00;
        end else begin
            forward_motion_ind <= low_q || high_q || forward_read;
            write_in_use <= low_q || high_q;
            write_available_a <= !(low_q || high_q);
            write_available_b <= !(low_q || high_q);
            write_available_c <= !(low_q || high_q);
            if (low_q && !high_q) begin
                density_ppi <= variant_q ? PPI_LOW_B : PPI_LOW_A;
            end else if (high_q && !low_q) begin
                density_ppi <= variant_q ? PPI_HIGH_B : PPI_HIGH_A;
            end else begin
                density_ppi <= 8'h00;
            end
            gap_tenths <= short_q ? GAP_SHORT_TENTHS : GAP_LONG_TENTHS;
        end
    end

    // ****************************************
    // Output buffer clear and load
    // ****************************************
    logic clear_start, clear_end;

    assign clear_start = preset_q && !clear_q && !firstreq_q && !bufrdy_q && slot_strobe && clear_window_phase
                         && !lower_preset_in && !tape_write_cycle;
    assign clear_end = clear_q && slot_strobe;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            preset_q <= 1'b0;
        end else if (wpr_p) begin
            preset_q <= 1'b1;
        end else if (clear_end) begin
            preset_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clear_q <= 1'b0;
        end else if (clear_start) begin
            clear_q <= 1'b1;
        end else if (clear_end) begin
            clear_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            firstreq_q <= 1'b0;
            bufrdy_q <= 1'b0;
            clear_done_request <= 1'b0;
            second_word_request <= 1'b0;
        end else begin
            clear_done_request <= clear_end;
            second_word_request <= firstreq_q && ack_p;
            if (clear_end) begin
                firstreq_q <= 1'b1;
            end else if (ack_p) begin
                firstreq_q <= 1'b0;
            end
            if (firstreq_q && ack_p) begin
                bufrdy_q <= 1'b1;
            end else if (start_confirm_pulse) begin
                bufrdy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            buffer_clear <= 1'b0;
            preset_out <= 1'b0;
        end else begin
            buffer_clear <= clear_start || (clear_q && !clear_end);
            preset_out <= preset_q || lower_preset_in;
        end
    end

    // ****************************************
    // Tape ready and write operate
    // ****************************************
    logic delay_done;

    tape_ready_timer #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .trigger(mot_p),
        .short_gap(short_q),
        .abort(wea_p),
        .done(delay_done)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            taperdy_q <= 1'b0;
        end else if (delay_done && !first_block) begin
            taperdy_q <= 1'b1;
        end else if (start_confirm_pulse) begin
            taperdy_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            start_q <= 1'b0;
        end else if (start_wr) begin
            start_q <= 1'b1;
        end else if (start_confirm_pulse) begin
            start_q <= 1'b0;
        end
    end

    // A start from the first-block state skips the tape delay via first_block; while bad_spot_pending is set, the start is held off.
    logic go;
    assign go = bufrdy_q && start_q && (taperdy_q || first_block) && !(first_block && bad_spot_pending)
                && !start_confirm_pulse && !wrdy_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            start_confirm_pulse <= 1'b0;
            wrdy_q <= 1'b0;
            inhibit_q <= 1'b0;
            write_operate <= 1'b0;
        end else begin
            start_confirm_pulse <= go;
            if (start_confirm_pulse) begin
                wrdy_q <= 1'b1;
            end else if (wea_p) begin
                wrdy_q <= 1'b0;
            end
            if (inhibit_set) begin
                inhibit_q <= 1'b1;
            end else if (start_confirm_pulse || inhibit_release) begin
                inhibit_q <= 1'b0;
            end
            write_operate <= (wrdy_q || start_confirm_pulse) && !inhibit_q && !wea_p;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_clear_one_slot: assert property (@(posedge sys_clk) disable iff (!rstn)
        clear_q |=> clear_q == !$past(slot_strobe))
        else $error("buffer clear flag held wrongly");
    a_clear_inhibit: assert property (@(posedge sys_clk) disable iff (!rstn)
        lower_preset_in |=> !$rose(clear_q))
        else $error("clear started under lower preset");
    a_clear_no_write: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(clear_q) |-> !$past(tape_write_cycle))
        else $error("clear started in write cycle");
    a_first_request: assert property (@(posedge sys_clk) disable iff (!rstn)
        clear_end |=> clear_done_request && firstreq_q)
        else $error("first word not requested");
    a_second_request: assert property (@(posedge sys_clk) disable iff (!rstn)
        (firstreq_q && ack_p) |=> second_word_request && bufrdy_q)
        else $error("second word not requested");
    a_start_needs_all: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(start_confirm_pulse) |-> $past(bufrdy_q) && $past(start_q))
        else $error("start without ready conditions");
    a_confirm_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_confirm_pulse |=> !start_q && !taperdy_q && wrdy_q)
        else $error("start confirm did not clear flags");
    a_gap_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wea_p && !setup_wr) |=> !short_q)
        else $error("short gap flag kept");
    a_density_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        (web_p && !setup_wr) |=> !low_q && !high_q)
        else $error("density flags kept");
    a_other_digit: assert property (@(posedge sys_clk) disable iff (!rstn)
        (setup_wr && op_digit != OP_LOW_DENSITY && op_digit != OP_HIGH_DENSITY && !wea_p && !web_p)
        |=> $stable({low_q, high_q, short_q}))
        else $error("other setup digit changed mode");
    c_clear_cycle: cover property (@(posedge sys_clk) disable iff (!rstn) clear_end);
    c_buffer_ready: cover property (@(posedge sys_clk) disable iff (!rstn) second_word_request);
    c_write_go: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(write_operate));

endmodule

// File: common/tape_wr_pkg.sv
package tape_wr_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] MODE_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam logic [11:0] SETUP_OFS = 12'h00C;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int MODE_LOW_BIT = 0;
    localparam int MODE_HIGH_BIT = 1;
    localparam int MODE_SHORT_BIT = 2;
    localparam int MODE_VARIANT_BIT = 3;
    localparam int SETUP_OP_LSB = 0;
    localparam int SETUP_GAP_BIT = 4;
    localparam int CTRL_START_BIT = 0;
    localparam int STAT_PRESET_BIT = 0;
    localparam int STAT_CLEAR_BIT = 1;
    localparam int STAT_FIRSTREQ_BIT = 2;
    localparam int STAT_BUFRDY_BIT = 3;
    localparam int STAT_TAPERDY_BIT = 4;
    localparam int STAT_START_BIT = 5;
    localparam int STAT_WRDY_BIT = 6;
    localparam int STAT_INHIBIT_BIT = 7;

    // ****************************************
    // Codes and reset values
    // ****************************************
    localparam logic [3:0] OP_LOW_DENSITY = 4'h7;
    localparam logic [3:0] OP_HIGH_DENSITY = 4'h5;
    localparam logic GAP_SHORT = 1'b0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ****************************************
    // Density and gap figures
    // ****************************************
    localparam logic [7:0] PPI_LOW_A = 8'h68;
    localparam logic [7:0] PPI_LOW_B = 8'h7D;
    localparam logic [7:0] PPI_HIGH_A = 8'hD0;
    localparam logic [7:0] PPI_HIGH_B = 8'hFA;
    localparam logic [7:0] GAP_SHORT_TENTHS = 8'h0A;
    localparam logic [7:0] GAP_LONG_TENTHS = 8'h18;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int SHORT_DELAY_US = 8700;
    localparam int LONG_DELAY_US = 22700;
    localparam int SHORT_DELAY_CYC = SHORT_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int LONG_DELAY_CYC = LONG_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int DELAY_W = 20;

endpackage

// File: verilog/tape_ready_timer.sv
`timescale 1ns/1ps
module tape_ready_timer
    import tape_wr_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_DELAY_CYC,
    parameter int LONG_CYC = LONG_DELAY_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic trigger,
    input wire logic short_gap,
    input wire logic abort,
    output logic done
);

    logic [DELAY_W-1:0] count_q;
    logic running_q;

    // Counts the gap-dependent tape acceleration delay after motion starts.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            running_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                running_q <= 1'b0;
            end else if (trigger) begin
                running_q <= 1'b1;
                count_q <= short_gap ? DELAY_W'(SHORT_CYC - 1) : DELAY_W'(LONG_CYC - 1);
            end else if (running_q) begin
                if (count_q == '0) begin
                    running_q <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

endmodule

// File: dv/dispatcher_model.sv
`timescale 1ns/1ps
// ****************************************
// Dispatcher model
// ****************************************
module dispatcher_model (
    input wire logic sys_clk,
    input wire logic [7:0] lat,
    input wire logic clear_done_request,
    output logic word_loaded_ack
);
    int cnt = 0;

    // The first word lands lat cycles after the request; the ack is held long enough to be synchronised.
    always @(posedge sys_clk) begin
        if (clear_done_request) begin
            cnt <= int'(lat) + 5;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    assign word_loaded_ack = (cnt > 0) && (cnt <= 5);
endmodule

// File: dv/test_tape_write_mode_and_start_control.sv
`timescale 1ns/1ps
module test_tape_write_mode_and_start_control;
    import tape_wr_pkg::*;
    localparam int SC = 20;
    localparam int LC = 50;
    typedef struct {logic [32:0] v; logic [31:0] m;} exp_s;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, vq = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [7:0] lat = '0, density_ppi, gap_tenths;
    logic pready, pslverr, word_loaded_ack, forward_motion_ind, write_in_use, write_available_a;
    logic write_available_b, write_available_c, buffer_clear, preset_out, clear_done_request;
    logic second_word_request, start_confirm_pulse, write_operate;
    logic write_end_pulse_a = 0, write_end_pulse_b = 0, forward_read = 0, write_preset_pulse = 0;
    logic slot_strobe = 0, clear_window_phase = 0, tape_write_cycle = 0, lower_preset_in = 0;
    logic motion_start = 0, first_block = 0, bad_spot_pending = 0, inhibit_set = 0, inhibit_release = 0;
    int errors = 0, check_count = 0, seed, n;
    exp_s exp_q[$];
    exp_s e;

    always #20 sys_clk = ~sys_clk;

    tape_write_start #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_dut (.sys_clk, .rstn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .write_end_pulse_a, .write_end_pulse_b, .forward_read,
        .write_preset_pulse, .slot_strobe, .clear_window_phase, .tape_write_cycle, .lower_preset_in,
        .word_loaded_ack, .motion_start, .first_block, .bad_spot_pending, .inhibit_set, .inhibit_release,
        .forward_motion_ind, .write_in_use, .write_available_a, .write_available_b, .write_available_c,
        .buffer_clear, .preset_out, .clear_done_request, .second_word_request, .start_confirm_pulse,
        .write_operate, .density_ppi, .gap_tenths);

    dispatcher_model i_disp (.sys_clk, .lat, .clear_done_request, .word_loaded_ack);

    // ****************************************
    // Checking
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read results are compared when the slave answers.
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk("prdata", e.v[31:0] & e.m, prdata & e.m);
            chk("pslverr", 32'(e.v[32]), 32'(pslverr));
        end
    end

    function automatic logic [7:0] ppi(input logic lo, input logic hi);
        if (lo && !hi) return vq ? 8'h7D : 8'h68;
        if (hi && !lo) return vq ? 8'hFA : 8'hD0;
        return 8'h00;
    endfunction

    // ****************************************
    // Drivers
    // ****************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x,
                       input logic [31:0] m);
        int k;
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) exp_q.push_back('{x, m});
        @(posedge sys_clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            $display("[ERR] pready expected 1 seen 0");
            end_sim();
        end
        psel <= 0;
        penable <= 0;
    endtask

    task automatic set_in(input int s, input logic v);
        case (s)
            0: write_end_pulse_a <= v;
            1: write_end_pulse_b <= v;
            2: write_preset_pulse <= v;
            default: motion_start <= v;
        endcase
    endtask

    task automatic pulse(input int s);
        @(posedge sys_clk);
        set_in(s, 1'b1);
        repeat (4) @(posedge sys_clk);
        set_in(s, 1'b0);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic strobe();
        @(posedge sys_clk);
        slot_strobe <= 1;
        @(posedge sys_clk);
        slot_strobe <= 0;
    endtask

    function automatic logic sig(input int s);
        case (s)
            1: return clear_done_request === 1'b1;
            2: return second_word_request === 1'b1;
            default: return start_confirm_pulse === 1'b1;
        endcase
    endfunction

    task automatic wait_on(input int s);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!sig(s) && n < 400);
        if (n >= 400) begin
            errors++;
            $display("[ERR] wait %0d expected 1 seen 0", s);
            end_sim();
        end
    endtask

    task automatic load();
        pulse(2);
        strobe();
        strobe();
        wait_on(1);
        wait_on(2);
    endtask

    task automatic mode(input logic lo, input logic hi, input logic sh);
        logic u;
        u = lo | hi;
        repeat (2) @(posedge sys_clk);
        chk("density_ppi", 32'(ppi(lo, hi)), 32'(density_ppi));
        chk("gap_tenths", sh ? 32'h0A : 32'h18, 32'(gap_tenths));
        chk("indications", 32'({u, u, !u, !u, !u}), 32'({forward_motion_ind, write_in_use, write_available_a,
            write_available_b, write_available_c}));
        apb(0, MODE_OFS, 32'h0, {29'h0, vq, sh, hi, lo}, 32'hFFFF_FFFF);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 8;
        repeat (2) @(posedge sys_clk);
        rstn <= 1;
        rd = $random(seed);
        lat <= {4'h0, rd[7:4]};
        vq = rd[3];
        apb(1, MODE_OFS, rd, '0, '0);
        mode(0, 0, 0);
        forward_read <= 1;
        repeat (2) @(posedge sys_clk);
        chk("forward_motion_ind", 32'h1, 32'(forward_motion_ind));
        forward_read <= 0;
        apb(1, SETUP_OFS, 32'h0000_0007, '0, '0);
        mode(1, 0, 1);
        apb(1, SETUP_OFS, 32'h0000_0003, '0, '0);
        mode(1, 0, 1);
        apb(1, SETUP_OFS, 32'h0000_0015, '0, '0);
        mode(0, 1, 1);
        pulse(0);
        mode(0, 1, 0);
        pulse(1);
        mode(0, 0, 0);
        apb(0, 12'h010, 32'h0, {1'b1, 32'h0}, 32'hFFFF_FFFF);
        apb(1, SETUP_OFS, 32'h0000_0007, '0, '0);
        mode(1, 0, 1);
        clear_window_phase <= 1;
        lower_preset_in <= 1;
        pulse(2);
        strobe();
        repeat (2) @(posedge sys_clk);
        chk("buffer_clear", 32'h0, 32'(buffer_clear));
        lower_preset_in <= 0;
        tape_write_cycle <= 1;
        strobe();
        repeat (2) @(posedge sys_clk);
        chk("buffer_clear", 32'h0, 32'(buffer_clear));
        chk("preset_out", 32'h1, 32'(preset_out));
        tape_write_cycle <= 0;
        strobe();
        repeat (2) @(posedge sys_clk);
        chk("buffer_clear", 32'h1, 32'(buffer_clear));
        strobe();
        wait_on(1);
        chk("buffer_clear", 32'h0, 32'(buffer_clear));
        wait_on(2);
        apb(0, STAT_OFS, 32'h0, 33'h0_0000_0008, 32'h0000_000C);
        apb(1, CTRL_OFS, 32'h0000_0001, '0, '0);
        chk("write_operate", 32'h0, 32'(write_operate));
        pulse(3);
        wait_on(3);
        chk("tape_delay_ok", 32'h1, 32'(n + 9 >= SC && n + 9 <= SC + 12));
        repeat (2) @(posedge sys_clk);
        chk("write_operate", 32'h1, 32'(write_operate));
        apb(0, STAT_OFS, 32'h0, 33'h0_0000_0040, 32'h0000_00F8);
        pulse(0);
        chk("write_operate", 32'h0, 32'(write_operate));
        pulse(1);
        mode(0, 0, 0);
        apb(1, SETUP_OFS, 32'h0000_0015, '0, '0);
        mode(0, 1, 0);
        load();
        apb(1, CTRL_OFS, 32'h0000_0001, '0, '0);
        pulse(3);
        wait_on(3);
        chk("tape_delay_ok", 32'h1, 32'(n + 9 >= LC && n + 9 <= LC + 12));
        inhibit_set <= 1;
        @(posedge sys_clk);
        inhibit_set <= 0;
        repeat (2) @(posedge sys_clk);
        chk("write_operate", 32'h0, 32'(write_operate));
        inhibit_release <= 1;
        @(posedge sys_clk);
        inhibit_release <= 0;
        repeat (2) @(posedge sys_clk);
        chk("write_operate", 32'h1, 32'(write_operate));
        pulse(0);
        pulse(1);
        apb(1, SETUP_OFS, 32'h0000_0007, '0, '0);
        load();
        first_block <= 1;
        bad_spot_pending <= 1;
        apb(1, CTRL_OFS, 32'h0000_0001, '0, '0);
        apb(0, STAT_OFS, 32'h0, 33'h0_0000_0020, 32'h0000_0060);
        bad_spot_pending <= 0;
        wait_on(3);
        chk("first_block_start", 32'h1, 32'(n <= 3));
        first_block <= 0;
        pulse(0);
        pulse(1);
        mode(0, 0, 0);
        end_sim();
    end
endmodule
